// >>> rtl/efal_regs.svh
// Constants for the E1 frame alignment supervision and channel mapping ends
// Summary of operation
// R1: B-channel uses one slot, 1-15 or 17-31
// R2: D-channel is slot 16; H0 any six
// R3: H1 uses all thirty payload slots
// R4: Idle D-channel sends back-to-back HDLC flags
// R5: Three consecutive bad alignment words lose alignment
// R6: No multiframe alignment within 8 ms loses alignment
// R7: 915 errored of 1000 sub-multiframes loses alignment
// R8: Optional three consecutive bad bit 2 loses alignment
// R9: Regain: good word, bit 2 one, good word
// R10: Multiframe alignment: two signals 2 ms apart, within 8 ms
// R11: Good alignment word clears bad-word counter
`ifndef EFAL_REGS_SVH
`define EFAL_REGS_SVH

`define EFAL_CLK_MHZ 100
`define EFAL_SLOTS 32
`define EFAL_SLOT_ALIGN 5'h00
`define EFAL_SLOT_D 5'h10
`define EFAL_FAS_WORD 7'h1b
`define EFAL_HDLC_FLAG 8'h7e
`define EFAL_BAD_LIMIT 2'h3
`define EFAL_MF_TIMEOUT_MS 8
`define EFAL_MF_STEP_MS 2
`define EFAL_FRAME_US 125
`define EFAL_MF_TIMEOUT_FRAMES 7'h40
`define EFAL_MF_STEP_FRAMES 7'h10
`define EFAL_SMF_WINDOW 10'h3e8
`define EFAL_SMF_ERR_LIMIT 10'h393
`define EFAL_MFAS_PATTERN 6'h0b

`endif

// >>> rtl/efal_pkg.sv
// Types shared by both ends of the E1 alignment link
package efal_pkg;
  typedef enum logic [2:0] {
    EFAL_CH_B = 3'h0,
    EFAL_CH_D = 3'h1,
    EFAL_CH_H0 = 3'h2,
    EFAL_CH_H1 = 3'h3,
    EFAL_CH_IDLE = 3'h4
  } efal_chan_t;

  typedef enum logic [3:0] {
    EFAL_SEARCH = 4'b0001,
    EFAL_FIRST = 4'b0010,
    EFAL_CONFIRM = 4'b0100,
    EFAL_LOCKED = 4'b1000
  } efal_align_t;
endpackage

// >>> rtl/efal_link_if.sv
// Octet-wide line link between transmitting peer and aligning receiver
`timescale 1ns/1ps
`default_nettype none
interface efal_link_if;
  logic [7:0] octet;
  logic octet_valid;
  modport tx (output octet, output octet_valid);
  modport rx (input octet, input octet_valid);
endinterface
`default_nettype wire

// >>> rtl/efal_tx.sv
// Transmitting end: builds frames, maps channels, fills idle D-channel
`timescale 1ns/1ps
`default_nettype none
`include "efal_regs.svh"
module efal_tx
  import efal_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  efal_link_if.tx link,
  input wire logic [4:0] b_slot,
  input wire logic [7:0] b_data,
  input wire logic [31:0] h0_slot_mask,
  input wire logic [7:0] h0_data,
  input wire logic h1_enable,
  input wire logic [7:0] h1_data,
  input wire logic d_valid,
  input wire logic [7:0] d_data,
  output logic d_ready,
  input wire logic [3:0] crc_bits,
  input wire logic [7:0] e_bits
);
  logic [4:0] slot_reg;
  logic [3:0] frame_reg;
  logic [7:0] octet_reg;
  logic valid_reg;
  logic [7:0] payload;
  logic [5:0] mfas_bits;

  assign mfas_bits = `EFAL_MFAS_PATTERN;

  // ------------------------------------------------------------
  // Slot validity
  // ------------------------------------------------------------
  function automatic logic payload_slot(input logic [4:0] s);
    return s != `EFAL_SLOT_ALIGN && s != `EFAL_SLOT_D; // see R1
  endfunction

  // ------------------------------------------------------------
  // Slot and frame counters
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      slot_reg <= 5'h00;
      frame_reg <= 4'h0;
    end else begin
      slot_reg <= slot_reg + 5'h01;
      if (slot_reg == 5'h1f) begin
        frame_reg <= frame_reg + 4'h1;
      end
    end
  end

  // Take one D octet each time slot 16 goes out
  assign d_ready = !reset && slot_reg == `EFAL_SLOT_D;

  // ------------------------------------------------------------
  // Channel mapping
  // ------------------------------------------------------------
  always_comb begin
    payload = 8'hff;
    if (h1_enable && payload_slot(slot_reg)) begin
      payload = h1_data; // see R3
    end else if (h0_slot_mask[slot_reg] && payload_slot(slot_reg)) begin
      payload = h0_data; // see R2
    end else if (slot_reg == b_slot && payload_slot(slot_reg)) begin
      payload = b_data; // see R1
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      octet_reg <= 8'hff;
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= 1'b1;
      if (slot_reg == `EFAL_SLOT_ALIGN) begin
        if (!frame_reg[0]) begin
          octet_reg <= {crc_bits[frame_reg[3:2]], `EFAL_FAS_WORD};
        end else if (frame_reg[3:1] < 3'h6) begin
          // Six-bit multiframe pattern in bit 1 of odd frames 1 to 11, bit 2 held one
          octet_reg <= {mfas_bits[3'h5 - frame_reg[3:1]], 7'h5f};
        end else begin
          octet_reg <= {e_bits[frame_reg[3:1]], 7'h5f};
        end
      end else if (slot_reg == `EFAL_SLOT_D) begin
        octet_reg <= d_valid ? d_data : `EFAL_HDLC_FLAG; // see R2, R4
      end else begin
        octet_reg <= payload;
      end
    end
  end

  assign link.octet = octet_reg;
  assign link.octet_valid = valid_reg;
endmodule // efal_tx
`default_nettype wire

// >>> rtl/efal_rx.sv
// Receiving end: basic frame and multiframe alignment supervision, demapping
`timescale 1ns/1ps
`default_nettype none
`include "efal_regs.svh"
module efal_rx
  import efal_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  efal_link_if.rx link,
  input wire logic bit2_check_en,
  input wire logic smf_errored,
  input wire logic smf_strobe,
  input wire logic [4:0] b_slot,
  input wire logic [31:0] h0_slot_mask,
  input wire logic h1_enable,
  output logic frame_aligned,
  output logic mf_aligned,
  output logic align_lost,
  output logic [7:0] rx_octet,
  output logic [4:0] rx_slot,
  output var efal_chan_t rx_chan,
  output logic rx_valid
);
  efal_align_t state_reg;
  logic [4:0] slot_reg;
  logic fas_frame_reg;
  logic [1:0] bad_fas_reg;
  logic [1:0] bad_bit2_reg;
  logic mf_lock_reg;
  logic [6:0] mf_timer_reg;
  logic [6:0] mf_since_reg;
  logic mf_seen_reg;
  logic [3:0] mf_shift_reg;
  logic [9:0] smf_count_reg;
  logic [9:0] smf_err_reg;
  logic lost;
  logic slot0;
  logic fas_ok;
  logic mfas_hit;
  logic smf_over;

  assign slot0 = link.octet_valid && slot_reg == `EFAL_SLOT_ALIGN;
  assign fas_ok = link.octet[6:0] == `EFAL_FAS_WORD;
  assign mfas_hit = {mf_shift_reg, link.octet[7]} == 5'h0b && mf_shift_reg[3:0] != 4'h0;
  assign smf_over = smf_errored && smf_err_reg + 10'h001 >= `EFAL_SMF_ERR_LIMIT;

  // ------------------------------------------------------------
  // Loss conditions
  // ------------------------------------------------------------
  always_comb begin
    lost = 1'b0;
    if (state_reg == EFAL_LOCKED && slot0) begin
      if (fas_frame_reg && !fas_ok && bad_fas_reg == 2'h2) begin
        lost = 1'b1; // see R5
      end
      if (!fas_frame_reg && bit2_check_en && !link.octet[6] && bad_bit2_reg == 2'h2) begin
        lost = 1'b1; // see R8
      end
    end
    if (state_reg == EFAL_LOCKED && !mf_lock_reg && mf_timer_reg >= `EFAL_MF_TIMEOUT_FRAMES) begin
      lost = 1'b1; // see R6
    end
    if (mf_lock_reg && smf_strobe && smf_over) begin
      lost = 1'b1; // see R7
    end
  end

  // ------------------------------------------------------------
  // Slot counter: slips one slot per failed search frame
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      slot_reg <= 5'h00;
    end else if (link.octet_valid) begin
      // Hunting shifts phase so a spurious word is not rehit
      if (state_reg == EFAL_SEARCH && slot_reg == `EFAL_SLOT_ALIGN && !fas_ok) begin
        slot_reg <= slot_reg + 5'h02;
      end else begin
        slot_reg <= slot_reg + 5'h01;
      end
    end
  end

  // ------------------------------------------------------------
  // Basic frame alignment
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= EFAL_SEARCH;
      fas_frame_reg <= 1'b1;
    end else if (lost) begin
      state_reg <= EFAL_SEARCH;
      fas_frame_reg <= 1'b1;
    end else if (slot0) begin
      fas_frame_reg <= !fas_frame_reg;
      unique case (state_reg)
        EFAL_SEARCH: begin
          fas_frame_reg <= 1'b0;
          if (fas_ok) begin
            state_reg <= EFAL_FIRST; // see R9
          end
        end
        EFAL_FIRST: begin
          state_reg <= link.octet[6] ? EFAL_CONFIRM : EFAL_SEARCH; // see R9
        end
        EFAL_CONFIRM: begin
          state_reg <= fas_ok ? EFAL_LOCKED : EFAL_SEARCH; // see R9
        end
        EFAL_LOCKED: begin
          state_reg <= EFAL_LOCKED;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset || lost || state_reg != EFAL_LOCKED) begin
      bad_fas_reg <= 2'h0;
      bad_bit2_reg <= 2'h0;
    end else if (slot0) begin
      if (fas_frame_reg) begin
        bad_fas_reg <= fas_ok ? 2'h0 : bad_fas_reg + 2'h1; // see R5, R11
      end else begin
        bad_bit2_reg <= link.octet[6] ? 2'h0 : bad_bit2_reg + 2'h1; // see R8
      end
    end
  end

  // ------------------------------------------------------------
  // Multiframe alignment search and timeout
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset || lost || state_reg != EFAL_LOCKED) begin
      mf_lock_reg <= 1'b0;
      mf_timer_reg <= 7'h00;
      mf_since_reg <= 7'h00;
      mf_seen_reg <= 1'b0;
      mf_shift_reg <= 4'h0;
    end else if (slot0) begin
      if (!mf_lock_reg) begin
        mf_timer_reg <= mf_timer_reg + 7'h01; // see R6
        mf_since_reg <= mf_since_reg + 7'h01;
      end
      if (!fas_frame_reg) begin
        mf_shift_reg <= {mf_shift_reg[2:0], link.octet[7]};
        if (mfas_hit && !mf_lock_reg) begin
          // Second hit a whole number of 2 ms steps later
          if (mf_seen_reg && mf_since_reg[3:0] == 4'h0) begin
            mf_lock_reg <= 1'b1; // see R10
          end
          mf_seen_reg <= 1'b1;
          // Hit frame counts as one, so a 16-frame gap reads 16 at the next hit
          mf_since_reg <= 7'h01;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Errored sub-multiframe window
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset || lost || !mf_lock_reg) begin
      smf_count_reg <= 10'h000;
      smf_err_reg <= 10'h000;
    end else if (smf_strobe) begin
      if (smf_count_reg == `EFAL_SMF_WINDOW - 10'h001) begin
        smf_count_reg <= 10'h000; // see R7
        smf_err_reg <= 10'h000;
      end else begin
        smf_count_reg <= smf_count_reg + 10'h001;
        smf_err_reg <= smf_err_reg + {9'h000, smf_errored};
      end
    end
  end

  // ------------------------------------------------------------
  // Outputs and channel demapping
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      align_lost <= 1'b0;
      rx_octet <= 8'h00;
      rx_slot <= 5'h00;
      rx_chan <= EFAL_CH_IDLE;
      rx_valid <= 1'b0;
    end else begin
      align_lost <= lost;
      rx_valid <= link.octet_valid && state_reg == EFAL_LOCKED;
      rx_octet <= link.octet;
      rx_slot <= slot_reg;
      if (slot_reg == `EFAL_SLOT_D) begin
        rx_chan <= EFAL_CH_D; // see R2
      end else if (slot_reg == `EFAL_SLOT_ALIGN) begin
        rx_chan <= EFAL_CH_IDLE;
      end else if (h1_enable) begin
        rx_chan <= EFAL_CH_H1; // see R3
      end else if (h0_slot_mask[slot_reg]) begin
        rx_chan <= EFAL_CH_H0;
      end else if (slot_reg == b_slot) begin
        rx_chan <= EFAL_CH_B; // see R1
      end else begin
        rx_chan <= EFAL_CH_IDLE;
      end
    end
  end

  assign frame_aligned = state_reg == EFAL_LOCKED;
  assign mf_aligned = mf_lock_reg;
endmodule // efal_rx
`default_nettype wire

// >>> test/efal_link_chk.sv
// Wire checks on the line link between the two ends
`timescale 1ns/1ps
`default_nettype none
module efal_link_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] octet,
  input wire logic octet_valid
);
  // ----
  // Slot and frame position
  // ----
  logic [5:0] pos_reg;
  wire logic s0 = octet_valid && pos_reg[4:0] == 5'h00;
  always_ff @(posedge clk) begin
    if (reset || !octet_valid) begin
      pos_reg <= 6'h00;
    end else begin
      pos_reg <= pos_reg + 6'h01;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_reset_line_idle: assert property ($fell(reset) |-> !octet_valid && octet == 8'hff)
    else $error("line not idle after reset");
  a_start_soon: assert property ($fell(reset) |-> ##[1:2] octet_valid)
    else $error("stream did not start");
  a_stream_holds: assert property (octet_valid |=> octet_valid)
    else $error("stream broke off");
  a_idle_all_ones: assert property (!octet_valid |-> octet == 8'hff)
    else $error("idle line not all ones");
  a_first_word: assert property ($rose(octet_valid) |-> octet[6:0] == 7'h1b)
    else $error("first octet is no alignment word");
  a_even_word: assert property (s0 && !pos_reg[5] |-> octet[6:0] == 7'h1b)
    else $error("alignment word missing");
  a_odd_bit2: assert property (s0 && pos_reg[5] |-> octet[6])
    else $error("bit 2 low in odd frame");
  a_frame_span: assert property (s0 && !pos_reg[5] |-> ##32 octet[6] ##32 octet[6:0] == 7'h1b)
    else $error("frame spacing wrong");
  c_start: cover property ($rose(octet_valid));
  c_flag: cover property (octet_valid && pos_reg[4:0] == 5'h10 && octet == 8'h7e);
  c_odd: cover property (s0 && pos_reg[5]);
endmodule // efal_link_chk
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench: both ends face to face, plus a scripted line
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import efal_pkg::*;
;
  typedef struct packed {
    logic [4:0] bs;
    logic [31:0] mask;
    logic h1;
    logic [4:0] probe;
    efal_chan_t chan;
    logic [7:0] oct;
    logic [4:0] n;
  } efal_row_t;
  efal_row_t rows [7] = '{
    '{5'h01, 32'h0, 1'b0, 5'h01, EFAL_CH_B, 8'h3c, 5'h01},
    '{5'h0f, 32'h0, 1'b0, 5'h0f, EFAL_CH_B, 8'h3c, 5'h01},
    '{5'h11, 32'h0, 1'b0, 5'h11, EFAL_CH_B, 8'h3c, 5'h01},
    '{5'h00, 32'h0, 1'b0, 5'h10, EFAL_CH_D, 8'h7e, 5'h01},
    '{5'h10, 32'h00010001, 1'b0, 5'h05, EFAL_CH_IDLE, 8'hff, 5'h1e},
    '{5'h01, 32'h000000fc, 1'b0, 5'h07, EFAL_CH_H0, 8'h5a, 5'h06},
    '{5'h00, 32'h0, 1'b1, 5'h1f, EFAL_CH_H1, 8'ha5, 5'h1e}
  };
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic rst_b = 1'b1;
  logic [4:0] b_slot = 5'h00;
  logic [31:0] h0_mask = 32'h0;
  logic h1_en = 1'b0;
  logic chk2 = 1'b0;
  logic strobe = 1'b0;
  logic errd = 1'b0;
  logic [7:0] b_dat = 8'h3c;
  logic [7:0] h0_dat = 8'h5a;
  logic [7:0] h1_dat = 8'ha5;
  logic d_val = 1'b0;
  logic [7:0] d_dat = 8'h42;
  logic d_rdy;
  logic fa_a, mf_a, lost_a, val_a, fa_b, lost_b;
  logic [7:0] oct_a;
  logic [4:0] slot_a, cnt;
  efal_chan_t chan_a;
  int num_errors = 0, comparisons = 0, cycles = 0, lost_na = 0, lost_nb = 0, n = 0;
  efal_link_if link_a ();
  efal_link_if link_b ();
  efal_tx u_efal_tx (.clk(clk), .reset(reset), .link(link_a), .b_slot(b_slot), .b_data(b_dat),
    .h0_slot_mask(h0_mask), .h0_data(h0_dat), .h1_enable(h1_en), .h1_data(h1_dat),
    .d_valid(d_val), .d_data(d_dat), .d_ready(d_rdy), .crc_bits(4'h0), .e_bits(8'hff));
  efal_rx u_efal_rx (.clk(clk), .reset(reset), .link(link_a), .bit2_check_en(chk2),
    .smf_errored(errd), .smf_strobe(strobe), .b_slot(b_slot), .h0_slot_mask(h0_mask),
    .h1_enable(h1_en), .frame_aligned(fa_a), .mf_aligned(mf_a), .align_lost(lost_a),
    .rx_octet(oct_a), .rx_slot(slot_a), .rx_chan(chan_a), .rx_valid(val_a));
  // Scripted line lets us break the alignment rules on purpose
  efal_rx u_efal_rx_b (.clk(clk), .reset(rst_b), .link(link_b), .bit2_check_en(chk2),
    .smf_errored(errd), .smf_strobe(strobe), .b_slot(b_slot), .h0_slot_mask(h0_mask),
    .h1_enable(h1_en), .frame_aligned(fa_b), .mf_aligned(), .align_lost(lost_b),
    .rx_octet(), .rx_slot(), .rx_chan(), .rx_valid());
  efal_link_chk u_efal_link_chk (.clk(clk), .reset(reset), .octet(link_a.octet),
    .octet_valid(link_a.octet_valid));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    lost_na <= lost_na + int'(lost_a);
    lost_nb <= lost_nb + int'(lost_b);
    if (cycles == 30000) begin
      num_errors++;
      summarize();
    end
  end
  // ----
  // Shared tasks
  // ----
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    comparisons++;
    if (seen !== want) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d, num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic frame_b(input logic [7:0] s0);
    for (int i = 0; i < 32; i++) begin
      link_b.octet = (i == 0) ? s0 : 8'hff;
      link_b.octet_valid = 1'b1;
      tick(1);
    end
  endtask
  task automatic pair_b(input logic fas_ok, input logic bit2_ok);
    frame_b(fas_ok ? 8'h1b : 8'h03);
    frame_b(bit2_ok ? 8'h40 : 8'h00);
  endtask
  task automatic lock_b;
    rst_b = 1'b1;
    tick(2);
    rst_b = 1'b0;
    pair_b(1'b1, 1'b1);
    check({7'h0, fa_b}, 8'h00);
    pair_b(1'b1, 1'b1);
    check({7'h0, fa_b}, 8'h01);
    n = lost_nb;
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    link_b.octet = 8'hff;
    link_b.octet_valid = 1'b0;
    tick(11);
    check({7'h0, link_a.octet_valid}, 8'h00);
    check({5'h0, chan_a}, {5'h0, EFAL_CH_IDLE});
    tick(1);
    reset = 1'b0;
    for (int i = 0; i < 6000 && fa_a !== 1'b1; i++) tick(1);
    check({7'h0, fa_a}, 8'h01);
    foreach (rows[r]) begin
      b_slot = rows[r].bs;
      h0_mask = rows[r].mask;
      h1_en = rows[r].h1;
      tick(96);
      cnt = 5'h00;
      repeat (32) begin
        if (val_a && slot_a != 5'h00 && chan_a === rows[r].chan) cnt++;
        if (val_a && slot_a == rows[r].probe) begin
          check({5'h0, chan_a}, {5'h0, rows[r].chan});
          check(oct_a, rows[r].oct);
        end
        tick(1);
      end
      check({3'h0, cnt}, {3'h0, rows[r].n});
    end
    // Offered D octets replace the idle flag; ready leads the received slot by two
    d_val = 1'b1;
    tick(96);
    repeat (32) begin
      check({7'h0, d_rdy}, {7'h0, slot_a == 5'h0e});
      if (slot_a == 5'h10) check(oct_a, d_dat);
      tick(1);
    end
    d_val = 1'b0;
    lock_b();
    for (int i = 0; i < 5; i++) pair_b(i == 2, 1'b1);
    check({7'h0, fa_b}, 8'h01);
    pair_b(1'b0, 1'b1);
    check(8'(lost_nb - n), 8'h01);
    check({7'h0, fa_b}, 8'h00);
    lock_b();
    repeat (30) pair_b(1'b1, 1'b1);
    check(8'(lost_nb - n), 8'h00);
    repeat (3) pair_b(1'b1, 1'b1);
    check(8'(lost_nb - n), 8'h01);
    for (int e = 1; e >= 0; e--) begin
      chk2 = e[0];
      lock_b();
      repeat (3) pair_b(1'b1, 1'b0);
      check(8'(lost_nb - n), {7'h0, e[0]});
    end
    check({7'h0, mf_a}, 8'h01);
    n = lost_na;
    for (int i = 1; i <= 915; i++) begin
      strobe = 1'b1;
      errd = 1'b1;
      tick(1);
      strobe = 1'b0;
      tick(3);
      if (i == 914) check(8'(lost_na - n), 8'h00);
    end
    check(8'(lost_na - n), 8'h01);
    summarize();
  end
endmodule // tb_top
`default_nettype wire
